/* sim/msdf_far.sv */
// far-side logic model: drives data, set and reset into the storage element
// assumes the bench supplies requests; feedback select closes q_n onto data
`timescale 1ns/1ns
module msdf_far
    import msdf_pkg::*;
(
    // requests from the bench
    input  wire logic fb_in,
    input  wire logic d_in,
    input  wire logic s_in,
    input  wire logic r_in,
    // feedback from the element
    input  wire logic q_n_in,
    // drive to the element
    output logic      data_out,
    output logic      set_out,
    output logic      reset_out
);
    assign data_out  = fb_in ? q_n_in : d_in;
    assign set_out   = s_in;
    // never both at once: set wins, so reset is held low while set is high
    assign reset_out = r_in & ~s_in;
endmodule

/* sim/tb.sv */
// self-checking bench for the master-slave storage element
// assumes the far-side model and a 10 MHz system clock
`timescale 1ns/1ns
module tb;
    import msdf_pkg::*;
    logic clk = 1'b0, rst = 1'b1, ca = 1'b0, cb = 1'b0, d = 1'b0, fb = 1'b0, s = 1'b0, r = 1'b0;
    wire  dat, st, rs, q, qn;
    int   error_cnt = 0;
    int   cmp_count = 0;
    always #50 clk = ~clk;
    msdf_far u_msdf_far (.fb_in(fb), .d_in(d), .s_in(s), .r_in(r), .q_n_in(qn),
        .data_out(dat), .set_out(st), .reset_out(rs));
    msdf_top u_msdf_top (.clk_in(clk), .rst_in(rst), .data_in(dat), .clock_in_a_in(ca),
        .clock_in_b_in(cb), .set_in(st), .reset_in(rs), .q_out(q), .q_n_out(qn));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic e);
        cmp_count++;
        if (q !== e || qn !== ~e)
        begin
            error_cnt++;
            $display("Error at %0t: q %b expected %b", $time, q, e);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // data flips at the rising edge itself, so a leaky master shows up
    task automatic t_capture;
        for (int i = 0; i < 3; i++)
        begin
            d = ~i[0];
            cyc(2);
            ca = ~i[0];
            cb = i[0];
            d = i[0];
            cyc(3);
            chk(~i[0]);
            cyc(3);
            chk(~i[0]);
            ca = 1'b0;
            cb = 1'b0;
            cyc(2);
            chk(~i[0]);
            d = i[0];
            cyc(3);
            chk(~i[0]);
        end
    endtask
    task automatic t_force;
        ca = 1'b1;
        d = 1'b0;
        s = 1'b1;
        cyc(3);
        chk(1'b1);
        s = 1'b0;
        cyc(3);
        chk(1'b1);
        r = 1'b1;
        cyc(3);
        chk(1'b0);
        r = 1'b0;
        cyc(3);
        chk(1'b0);
        ca = 1'b0;
    endtask
    // a mid-run reset must clear a forced high with the clocks quiet
    task automatic t_reset;
        s = 1'b1;
        cyc(2);
        chk(1'b1);
        s = 1'b0;
        rst = 1'b1;
        cyc(2);
        chk(MSDF_RST_STORE);
        rst = 1'b0;
        cyc(2);
        chk(MSDF_RST_STORE);
    endtask
    task automatic t_toggle;
        fb = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            cyc(3);
            cb = 1'b1;
            cyc(3);
            chk(~i[0]);
            cb = 1'b0;
        end
    endtask
    initial
    begin
        cyc(16);
        rst = 1'b0;
        cyc(2);
        chk(1'b0);
        t_capture();
        t_force();
        t_reset();
        t_toggle();
        stop_test();
    end
    // whole run is about 100 cycles; ten times that means a hang
    initial
    begin
        repeat (1000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
endmodule

/* verilog/msdf_pkg.sv */
// package for the master-slave d storage element
// assumes a single 10 MHz system clock; all inputs synchronous to it
package msdf_pkg;
    localparam logic MSDF_RST_STORE = 1'b0;
    localparam logic MSDF_RST_CLOCK = 1'b0;
    localparam int   MSDF_CLK_PERIOD_NS = 100;
endpackage

/* verilog/msdf_stage.sv */
// one storage stage: holds a bit, loads it on enable, forced by set or reset
// assumes the caller resolves priorities; asynchronous reset to a constant
`timescale 1ns/1ns
module msdf_stage
    import msdf_pkg::*;
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // control
    input  wire logic load_in,
    input  wire logic force_in,
    input  wire logic force_val_in,
    input  wire logic data_in,
    // state
    output logic      value_out
);
    typedef struct packed
    {
        logic value;
    } msdf_stage_t;

    msdf_stage_t st_q;
    msdf_stage_t st_d;

    always_comb
    begin
        st_d = st_q;
        if (force_in)
        begin
            st_d.value = force_val_in;
        end
        else if (load_in)
        begin
            st_d.value = data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_q <= '{value: MSDF_RST_STORE};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign value_out = st_q.value;
endmodule

/* verilog/msdf_top.sv */
// master-slave d storage element with two ored clock inputs and set/reset
// assumes clock, data, set and reset inputs are synchronous to clk_in
// Notes on behaviour
// - clocks low: data reaches master only
// - effective clock rising: master copied to slave
// - either clock high: master ignores data
// - steady clock: slave and outputs hold
// - clock falling: slave locks, master follows data
// - master closes before transfer opens
// - set forces high, reset low, override all
// - set/reset load master and slave both
// - inverted output fed back toggles each rising edge
// - unconnected inputs are not pulled low here; the boundary must pull them low
`timescale 1ns/1ns
module msdf_top
    import msdf_pkg::*;
(
    // system clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // element inputs
    input  wire logic data_in,
    input  wire logic clock_in_a_in,
    input  wire logic clock_in_b_in,
    input  wire logic set_in,
    input  wire logic reset_in,
    // element outputs
    output logic      q_out,
    output logic      q_n_out
);
    typedef struct packed
    {
        logic clk_prev;
        logic q;
        logic q_n;
    } msdf_state_t;

    msdf_state_t st_q;
    msdf_state_t st_d;
    logic        eff_clk;
    logic        rise;
    logic        force_any;
    logic        force_val;
    logic        master;
    logic        slave;

    // inputs are plain synchronous levels; an undriven pin is expected to be pulled
    // low at the boundary, so only a high level ever acts here
    assign eff_clk   = clock_in_a_in | clock_in_b_in;
    assign rise      = eff_clk & ~st_q.clk_prev;
    // set takes priority if both are asserted; the outside must not do that
    assign force_any = set_in | reset_in;
    assign force_val = set_in;

    // master follows data only while the effective clock is low; a rising edge
    // shuts it in the same cycle, so fed-back data cannot race through
    msdf_stage u_master
    (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .load_in      (~eff_clk),
        .force_in     (force_any),
        .force_val_in (force_val),
        .data_in      (data_in),
        .value_out    (master)
    );

    // slave samples the master value held before this cycle's data
    msdf_stage u_slave
    (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .load_in      (rise),
        .force_in     (force_any),
        .force_val_in (force_val),
        .data_in      (master),
        .value_out    (slave)
    );

    always_comb
    begin
        st_d          = st_q;
        st_d.clk_prev = eff_clk;
        // outputs mirror the slave's next value so they stay flip-flop driven
        if (force_any)
        begin
            st_d.q = force_val;
        end
        else if (rise)
        begin
            st_d.q = master;
        end
        st_d.q_n = ~st_d.q;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_q <= '{clk_prev: MSDF_RST_CLOCK, q: MSDF_RST_STORE, q_n: ~MSDF_RST_STORE};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign q_out   = st_q.q;
    assign q_n_out = st_q.q_n;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    a_comp_outputs: assert property (q_n_out == ~q_out)
        else $error("inverted output not complement");
    a_slave_tracks: assert property (q_out == slave)
        else $error("output differs from slave");
    a_edge_xfer: assert property (!force_any && rise |=> q_out == $past(master))
        else $error("edge did not transfer master");
    a_hold_steady: assert property (!force_any && !rise |=> $stable(q_out))
        else $error("output changed without edge");
    a_master_closed: assert property (eff_clk && !force_any |=> $stable(master))
        else $error("master moved while clock high");
    a_master_open: assert property (!eff_clk && !force_any |=> master == $past(data_in))
        else $error("master did not follow data");
    a_set_force: assert property (set_in |=> q_out && master)
        else $error("set did not force high");
    a_reset_force: assert property (reset_in && !set_in |=> !q_out && !master)
        else $error("reset did not force low");
    a_fall_lock: assert property (!force_any && $fell(eff_clk) |=> $stable(q_out))
        else $error("output moved on falling edge");

    c_rise: cover property (rise && !force_any);
    c_set: cover property (set_in ##1 !set_in);
    c_reset: cover property (reset_in ##1 !reset_in);
    c_toggle: cover property (rise && data_in == q_n_out ##6 rise);
    c_fall: cover property ($fell(eff_clk) && !force_any);

    // finer checks on the two stages; these catch a leaky master or a slave
    // that moves without a clean edge, which the output checks alone would miss

    // a rising edge shuts the master before the slave opens
    a_rise_shuts_master: assert property (
        rise && !force_any |=> master == $past(master))
        else $error("master took data on the rising edge");

    // the clock history must be last cycle's effective clock
    a_clock_history: assert property (
        1'b1 |=> st_q.clk_prev == $past(eff_clk))
        else $error("clock history lost");

    // a held high clock gives one edge only
    a_rise_single: assert property (
        rise |=> !rise)
        else $error("edge seen twice");

    // set or reset puts the same value in both stages
    a_force_aligns: assert property (
        force_any |=> master == slave)
        else $error("stages differ after force");

    // a released set leaves both stages high
    a_set_persists: assert property (
        set_in ##1 (!force_any && !rise) |-> q_out && master)
        else $error("set state not kept");

    // a released reset leaves both stages low
    a_reset_persists: assert property (
        reset_in && !set_in ##1 (!force_any && !rise) |-> !q_out && !master)
        else $error("reset state not kept");

    // an edge with a differing master must flip the output
    a_toggle_step: assert property (
        rise && !force_any && master != q_out |=> q_out != $past(q_out))
        else $error("output did not toggle");

    // low clock: data may reach the master only
    a_low_clock_quiet: assert property (
        !eff_clk && !force_any |=> $stable(q_out) && $stable(slave))
        else $error("slave moved while clock low");

    // high clock after its edge: nothing moves
    a_high_clock_quiet: assert property (
        eff_clk && !rise && !force_any |=> $stable(q_out) && $stable(master))
        else $error("state moved while clock high");

    // set wins over a coincident edge
    a_set_over_clock: assert property (
        set_in && rise |=> q_out)
        else $error("edge beat set");

    // reset wins over a coincident edge
    a_reset_over_clock: assert property (
        reset_in && !set_in && rise |=> !q_out)
        else $error("edge beat reset");

    // reset wins over data flowing into an open master
    a_reset_over_data: assert property (
        reset_in && !set_in && !eff_clk |=> !master)
        else $error("data beat reset in master");

    // after a falling edge the master tracks data again
    a_fall_master_opens: assert property (
        $fell(eff_clk) && !force_any |=> master == $past(data_in))
        else $error("master closed after fall");

    // two low clock pins give a low effective clock
    a_idle_clock_low: assert property (
        !clock_in_a_in && !clock_in_b_in |-> !eff_clk)
        else $error("idle clocks read high");

    // an output change needs an edge or a force one cycle before
    a_output_edge_only: assert property (
        $changed(q_out) && !$past(force_any) |-> $past(rise))
        else $error("output changed without cause");

    // the slave changes only by copying the master on an edge
    a_slave_from_master: assert property (
        $changed(slave) && !$past(force_any) |-> $past(rise) && slave == $past(master))
        else $error("slave changed without transfer");
endmodule
